/* ssf_map.svh */
// Register offsets, field positions and reset values of the serial buffer status block
`ifndef SSF_MAP_SVH
`define SSF_MAP_SVH
`define SSF_OFS_STATUS 12'h000
`define SSF_OFS_DATA   12'h004
`define SSF_OFS_CTRL   12'h008
`define SSF_BIT_TBE    3
`define SSF_BIT_RSVD   2
`define SSF_BIT_TBF    1
`define SSF_BIT_RBF    0
`define SSF_BIT_ENH    0
`define SSF_RST_CTRL   32'h0000_0000
`define SSF_RST_TBE    1'b1
`endif

/* ssf_pkg.sv */
// Types shared by the serial buffer status block
`default_nettype none
package ssf_pkg;
  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ssf_apb_req_t;
  // Buffering mode
  typedef enum logic {SSF_MODE_STD, SSF_MODE_ENH} ssf_mode_t;
endpackage
`default_nettype wire

/* ssf_top.sv */
// Serial port with holding buffers, shift register and buffer status flags
// Operation
// R01: Status bit 3 reads 1 when the transmit holding buffer is empty and 0 when a word waits. In enhanced mode any transfer sets it, even with words left.
// R02: The transmit-empty flag is set when a word moves from the transmit buffer into the shift register.
// R03: The transmit-empty flag is cleared whenever the core writes the data window register; the code keeps it set if a load falls in that cycle.
// R04: Status bit 2 always reads 0.
// R05: In standard mode a data window write sets the transmit-full flag at bit 1.
// R06: In standard mode the transmit-full flag clears when the held word moves into the shift register.
// R07: In enhanced mode transmit-full is 1 exactly when core write pointer plus one equals shift read pointer.
// R08: In standard mode receive-full at bit 0 sets when a received word moves into the receive buffer.
// R09: In standard mode receive-full clears when the core reads the data window register.
// R10: In enhanced mode receive-full is 1 exactly when shift write pointer plus one equals core read pointer.
// R11: A control bit picks standard or enhanced buffering, and enhanced mode steps pointers per access.
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ssf_map.svh"
module ssf_top #(
  parameter int DW    = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  // APB slave
  input  wire ssf_pkg::ssf_apb_req_t apb_req,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  // Serial link
  input  wire logic                 link_sck,
  input  wire logic                 link_ss_n,
  input  wire logic                 link_sdi,
  output logic                      link_sdo
);
  import ssf_pkg::*;
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DW);

  // Buffer index: standard mode always uses slot 0
  function automatic logic [PW-1:0] slot(input ssf_mode_t m, input logic [PW-1:0] p);
    slot = (m == SSF_MODE_ENH) ? p : '0;
  endfunction

  // Pin synchronisers and edge history
  logic [2:0] s1_ff, s2_ff, nxt_s1, nxt_s2;
  logic       sck_d_ff, ss_d_ff, nxt_sck_d, nxt_ss_d;
  always_comb begin
    nxt_s1    = {link_sck, link_ss_n, link_sdi};
    nxt_s2    = s1_ff;
    nxt_sck_d = s2_ff[2];
    nxt_ss_d  = s2_ff[1];
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_ff    <= 3'h2; // Link clock idles low, select idles high
      s2_ff    <= 3'h2;
      sck_d_ff <= 1'b0;
      ss_d_ff  <= 1'b1;
    end else begin
      s1_ff    <= nxt_s1;
      s2_ff    <= nxt_s2;
      sck_d_ff <= nxt_sck_d;
      ss_d_ff  <= nxt_ss_d;
    end
  end

  logic sck_rise, sck_fall, ss_fall, sel;
  assign sel      = ~s2_ff[1];
  assign sck_rise = sel & s2_ff[2] & ~sck_d_ff;
  assign sck_fall = sel & ~s2_ff[2] & sck_d_ff;
  assign ss_fall  = ~s2_ff[1] & ss_d_ff;

  // APB access decode
  logic acc, wr_data, rd_data, wr_ctrl, acc_stat;
  logic pready_ff, pslverr_ff, nxt_pready, nxt_pslverr;
  logic [31:0] prdata_ff, nxt_prdata;
  assign acc      = apb_req.psel & apb_req.penable & pready_ff;
  assign wr_data  = acc & apb_req.pwrite & (apb_req.paddr == `SSF_OFS_DATA);
  assign rd_data  = acc & ~apb_req.pwrite & (apb_req.paddr == `SSF_OFS_DATA);
  assign wr_ctrl  = acc & apb_req.pwrite & (apb_req.paddr == `SSF_OFS_CTRL);
  assign acc_stat = acc & ~apb_req.pwrite & (apb_req.paddr == `SSF_OFS_STATUS);

  // Control, buffers, pointers and flags
  ssf_mode_t   mode_ff, nxt_mode;
  logic [DW-1:0] tx_mem_ff [DEPTH];
  logic [DW-1:0] rx_mem_ff [DEPTH];
  logic [DW-1:0] nxt_tx_mem [DEPTH];
  logic [DW-1:0] nxt_rx_mem [DEPTH];
  logic [PW-1:0] core_write_pointer_ff, shift_read_pointer_ff, shift_write_pointer_ff, core_read_pointer_ff;
  logic [PW-1:0] nxt_core_write_pointer, nxt_shift_read_pointer, nxt_shift_write_pointer, nxt_core_read_pointer;
  logic          tbe_ff, tbf_ff, rbf_ff, nxt_tbe, nxt_tbf, nxt_rbf;
  logic [DW-1:0] sr_ff, nxt_sr;
  logic [CW-1:0] bit_ff, nxt_bit;
  logic          sdo_ff, nxt_sdo;
  logic          armed_ff, nxt_armed;
  logic          enh, tbf, rbf, tx_pend, rx_avail, load_ev, rx_done, push_ok;
  logic [DW-1:0] rx_word;

  assign enh      = (mode_ff == SSF_MODE_ENH);
  assign tbf      = enh ? (PW'(core_write_pointer_ff + 1'b1) == shift_read_pointer_ff) : tbf_ff; // [R07]
  assign rbf      = enh ? (PW'(shift_write_pointer_ff + 1'b1) == core_read_pointer_ff) : rbf_ff; // [R10]
  assign tx_pend  = enh ? (core_write_pointer_ff != shift_read_pointer_ff) : tbf_ff;
  assign rx_avail = enh ? (core_read_pointer_ff != shift_write_pointer_ff) : rbf_ff;
  assign rx_done  = sck_rise & (bit_ff == CW'(DW - 1));
  assign rx_word  = {sr_ff[DW-2:0], s2_ff[0]};
  assign load_ev  = ((ss_fall & ~armed_ff) | rx_done) & tx_pend; // Armed word is not replaced
  assign push_ok  = wr_data & ~tbf;

  // Next state of buffers, pointers and flags
  always_comb begin
    nxt_mode  = mode_ff;
    nxt_tx_mem = tx_mem_ff;
    nxt_rx_mem = rx_mem_ff;
    nxt_core_write_pointer = core_write_pointer_ff;
    nxt_shift_read_pointer = shift_read_pointer_ff;
    nxt_shift_write_pointer = shift_write_pointer_ff;
    nxt_core_read_pointer = core_read_pointer_ff;
    nxt_tbe   = tbe_ff;
    nxt_tbf   = tbf_ff;
    nxt_rbf   = rbf_ff;
    // Core write fills the transmit buffer
    if (wr_data) begin
      nxt_tbe = 1'b0; // [R03]
    end
    if (push_ok) begin
      nxt_tx_mem[slot(mode_ff, core_write_pointer_ff)] = apb_req.pwdata[DW-1:0];
      if (enh) begin
        nxt_core_write_pointer = PW'(core_write_pointer_ff + 1'b1); // [R11]
      end else begin
        nxt_tbf = 1'b1; // [R05]
      end
    end
    // Transfer into the shift register; set beats clear
    if (load_ev) begin
      nxt_tbe = 1'b1; // [R02]
      if (enh) begin
        nxt_shift_read_pointer = PW'(shift_read_pointer_ff + 1'b1); // [R11]
      end else begin
        nxt_tbf = 1'b0; // [R06]
      end
    end
    // Core read drains the receive buffer
    if (rd_data && rx_avail) begin
      if (enh) begin
        nxt_core_read_pointer = PW'(core_read_pointer_ff + 1'b1); // [R11]
      end else begin
        nxt_rbf = 1'b0; // [R09]
      end
    end
    // Completed word moves into the receive buffer, dropped when full
    if (rx_done && !rbf) begin
      nxt_rx_mem[slot(mode_ff, shift_write_pointer_ff)] = rx_word;
      if (enh) begin
        nxt_shift_write_pointer = PW'(shift_write_pointer_ff + 1'b1); // [R11]
      end else begin
        nxt_rbf = 1'b1; // [R08]
      end
    end
    // Mode change empties both buffers
    if (wr_ctrl) begin
      nxt_mode  = apb_req.pwdata[`SSF_BIT_ENH] ? SSF_MODE_ENH : SSF_MODE_STD; // [R11]
      nxt_core_write_pointer = '0;
      nxt_shift_read_pointer = '0;
      nxt_shift_write_pointer = '0;
      nxt_core_read_pointer = '0;
      nxt_tbe   = `SSF_RST_TBE;
      nxt_tbf   = 1'b0;
      nxt_rbf   = 1'b0;
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_ff  <= SSF_MODE_STD;
      for (int i = 0; i < DEPTH; i++) begin
        tx_mem_ff[i] <= '0;
        rx_mem_ff[i] <= '0;
      end
      core_write_pointer_ff <= '0;
      shift_read_pointer_ff <= '0;
      shift_write_pointer_ff <= '0;
      core_read_pointer_ff <= '0;
      tbe_ff   <= `SSF_RST_TBE;
      tbf_ff   <= 1'b0;
      rbf_ff   <= 1'b0;
    end else begin
      mode_ff   <= nxt_mode;
      tx_mem_ff <= nxt_tx_mem;
      rx_mem_ff <= nxt_rx_mem;
      core_write_pointer_ff  <= nxt_core_write_pointer;
      shift_read_pointer_ff  <= nxt_shift_read_pointer;
      shift_write_pointer_ff  <= nxt_shift_write_pointer;
      core_read_pointer_ff  <= nxt_core_read_pointer;
      tbe_ff    <= nxt_tbe;
      tbf_ff    <= nxt_tbf;
      rbf_ff    <= nxt_rbf;
    end
  end

  // Shift register: sample on rising sck, drive on falling sck
  always_comb begin
    nxt_sr    = sr_ff;
    nxt_bit   = bit_ff;
    nxt_sdo   = sdo_ff;
    nxt_armed = armed_ff;
    if (ss_fall) begin
      nxt_bit = '0;
      // A word loaded at the last boundary is still unsent: keep it
      if (!armed_ff) begin
        nxt_sr = load_ev ? tx_mem_ff[slot(mode_ff, shift_read_pointer_ff)] : '0;
      end
      nxt_sdo = nxt_sr[DW-1];
    end else if (sck_rise) begin
      nxt_bit   = rx_done ? '0 : CW'(bit_ff + 1'b1);
      nxt_sr    = rx_done ? (load_ev ? tx_mem_ff[slot(mode_ff, shift_read_pointer_ff)] : '0) : rx_word;
      nxt_armed = rx_done & load_ev; // Word waits for the next frame or bit
    end else if (sck_fall) begin
      nxt_sdo = sr_ff[DW-1];
    end
    // Mode change drops any armed word
    if (wr_ctrl) begin
      nxt_armed = 1'b0;
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sr_ff    <= '0;
      bit_ff   <= '0;
      sdo_ff   <= 1'b0;
      armed_ff <= 1'b0;
    end else begin
      sr_ff    <= nxt_sr;
      bit_ff   <= nxt_bit;
      sdo_ff   <= nxt_sdo;
      armed_ff <= nxt_armed;
    end
  end

  // APB answer: ready in the access cycle, read data taken at setup
  always_comb begin
    nxt_pready  = apb_req.psel & ~apb_req.penable;
    nxt_pslverr = 1'b0;
    nxt_prdata  = '0;
    if (apb_req.psel && !apb_req.penable) begin
      unique case (apb_req.paddr)
        `SSF_OFS_STATUS: begin
          nxt_prdata[`SSF_BIT_TBE]  = tbe_ff; // [R01]
          nxt_prdata[`SSF_BIT_RSVD] = 1'b0;   // [R04]
          nxt_prdata[`SSF_BIT_TBF]  = tbf;
          nxt_prdata[`SSF_BIT_RBF]  = rbf;
        end
        `SSF_OFS_DATA: nxt_prdata[DW-1:0] = rx_mem_ff[slot(mode_ff, core_read_pointer_ff)];
        `SSF_OFS_CTRL: nxt_prdata[`SSF_BIT_ENH] = enh;
        default:       nxt_pslverr = 1'b1;
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end else begin
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff  <= nxt_prdata;
    end
  end
  assign pready   = pready_ff;
  assign pslverr  = pslverr_ff;
  assign prdata   = prdata_ff;
  assign link_sdo = sdo_ff;

  // Checks
  sequence seq_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence seq_answer;
    pready_ff ##1 !pready_ff;
  endsequence
  a_apb_answer: assert property (@(posedge core_clk) disable iff (!reset_n)
    seq_setup |=> seq_answer) else $error("APB answer not one cycle");
  a_tbe_status: assert property (@(posedge core_clk) disable iff (!reset_n) // [R01]
    acc_stat |-> prdata_ff[`SSF_BIT_TBE] == $past(tbe_ff)) else $error("Empty bit wrong");
  a_tbe_on_load: assert property (@(posedge core_clk) disable iff (!reset_n) // [R02]
    load_ev && !wr_ctrl |=> tbe_ff) else $error("Empty not set on load");
  a_tbe_on_write: assert property (@(posedge core_clk) disable iff (!reset_n) // [R03]
    wr_data && !load_ev |=> !tbe_ff) else $error("Empty not cleared on write");
  a_rsvd_zero: assert property (@(posedge core_clk) disable iff (!reset_n) // [R04]
    acc_stat |-> !prdata_ff[`SSF_BIT_RSVD]) else $error("Bit 2 not zero");
  a_tbf_std_set: assert property (@(posedge core_clk) disable iff (!reset_n) // [R05]
    !enh && push_ok && !load_ev && !wr_ctrl |=> tbf_ff ##1 tbf_ff || $past(load_ev))
    else $error("Full not set on write");
  a_tbf_std_clr: assert property (@(posedge core_clk) disable iff (!reset_n) // [R06]
    !enh && load_ev && !wr_data |=> !tbf_ff) else $error("Full not cleared on load");
  a_tbf_enh: assert property (@(posedge core_clk) disable iff (!reset_n) // [R07]
    enh && push_ok && (PW'(core_write_pointer_ff + 2'd2) == shift_read_pointer_ff) && !load_ev |=> tbf)
    else $error("Enhanced full not raised");
  a_rbf_std_set: assert property (@(posedge core_clk) disable iff (!reset_n) // [R08]
    !enh && rx_done && !wr_ctrl && !(rd_data && rbf_ff) |=> rbf_ff) else $error("Receive full not set");
  a_rbf_std_clr: assert property (@(posedge core_clk) disable iff (!reset_n) // [R09]
    !enh && rd_data && !rx_done |=> !rbf_ff) else $error("Receive full not cleared");
  a_rbf_enh: assert property (@(posedge core_clk) disable iff (!reset_n) // [R10]
    enh && rx_done && !rbf && !rd_data && !wr_ctrl && (PW'(shift_write_pointer_ff + 2'd2) == core_read_pointer_ff) |=> rbf)
    else $error("Enhanced receive full not raised");
  a_ptr_step: assert property (@(posedge core_clk) disable iff (!reset_n) // [R11]
    enh && push_ok && !wr_ctrl |=> core_write_pointer_ff == PW'($past(core_write_pointer_ff) + 1'b1))
    else $error("Write pointer did not step");
endmodule // ssf_top
`default_nettype wire

/* ssf_link_model.sv */
// Behavioural serial link master that frames one word at a time
`timescale 1ns/1ps
`default_nettype none
module ssf_link_model (
  // Serial link
  output logic     link_sck,
  output logic     link_ss_n,
  output logic     link_sdi,
  input wire logic link_sdo
);
  // Clock and select stand idle between frames
  initial begin
    link_sck  = 1'b0;
    link_ss_n = 1'b1;
    link_sdi  = 1'b0;
  end
  // One 8-bit frame, MSB first, 80 ns clock, reply sampled on the rising clock
  task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
    int i;
    link_ss_n = 1'b0;
    #200;
    for (i = 7; i >= 0; i--) begin
      link_sdi = tx[i];
      #40 link_sck = 1'b1;
      rx[i] = link_sdo;
      #40 link_sck = 1'b0;
    end
    #100 link_ss_n = 1'b1;
    link_sdi = ~link_sdi; // Released line parks on the inverse of its last bit
  endtask
endmodule // ssf_link_model
`default_nettype wire

/* ssf_top_tb.sv */
// Self-checking bench for the serial buffer status block
`timescale 1ns/1ps
`default_nettype none
`include "ssf_map.svh"
module ssf_top_tb;
  import ssf_pkg::*;
  logic                core_clk;
  logic                reset_n;
  ssf_apb_req_t        apb_req;
  logic                pready;
  logic                pslverr;
  logic [31:0]         prdata;
  logic                link_sck;
  logic                link_ss_n;
  logic                link_sdi;
  logic                link_sdo;
  logic [31:0]         rd;
  logic                err;
  logic [7:0]          rx;
  int                  num_errors;
  int                  samples_checked;
  int                  k;
  // Device and far-side link master
  ssf_top ssf_top_i (.core_clk(core_clk), .reset_n(reset_n), .apb_req(apb_req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .link_sck(link_sck), .link_ss_n(link_ss_n),
    .link_sdi(link_sdi), .link_sdo(link_sdo));
  ssf_link_model ssf_link_model_i (.link_sck(link_sck), .link_ss_n(link_ss_n), .link_sdi(link_sdi),
    .link_sdo(link_sdo));
  // 125 MHz clock
  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;
  // One APB transfer; waits for pready with no count limit
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask
  // Compare a 32-bit result
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Expected status word from the three flags
  function automatic logic [31:0] st(input logic tbe, input logic tbf, input logic rbf);
    st = (32'(tbe) << `SSF_BIT_TBE) | (32'(tbf) << `SSF_BIT_TBF) | (32'(rbf) << `SSF_BIT_RBF);
  endfunction
  // Status read and compare
  task automatic st_chk(input logic tbe, input logic tbf, input logic rbf);
    apb(1'b0, `SSF_OFS_STATUS, 32'h0);
    chk("status", st(tbe, tbf, rbf), rd);
  endtask
  // Counts and verdict
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog
  initial begin
    #200000;
    num_errors++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    num_errors = 0;
    samples_checked = 0;
    apb_req = '0;
    reset_n = 1'b0;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    st_chk(1'b1, 1'b0, 1'b0);
    apb(1'b1, `SSF_OFS_DATA, 32'hFFFF_FFA5);
    st_chk(1'b0, 1'b1, 1'b0);
    ssf_link_model_i.frame(8'h3C, rx);
    repeat (10) @(posedge core_clk);
    chk("link word", 32'h0000_00A5, {24'h0, rx});
    st_chk(1'b1, 1'b0, 1'b1);
    apb(1'b0, `SSF_OFS_DATA, 32'h0);
    chk("rx data", 32'h0000_003C, rd);
    st_chk(1'b1, 1'b0, 1'b0);
    apb(1'b1, 12'h00C, 32'h0000_0001);
    chk("unmapped error", 32'h1, {31'h0, err});
    st_chk(1'b1, 1'b0, 1'b0);
    // Enhanced mode: three words fill a four-entry ring
    apb(1'b1, `SSF_OFS_CTRL, 32'h0000_0001);
    chk("ctrl", 32'h0, {31'h0, err});
    apb(1'b0, `SSF_OFS_CTRL, 32'h0);
    chk("ctrl mode", 32'h1, rd);
    for (k = 1; k <= 3; k++) begin
      st_chk(k == 1, 1'b0, 1'b0);
      apb(1'b1, `SSF_OFS_DATA, 32'(k));
    end
    st_chk(1'b0, 1'b1, 1'b0);
    for (k = 1; k <= 3; k++) begin
      ssf_link_model_i.frame(8'(k * 17), rx);
      repeat (10) @(posedge core_clk);
      chk("enh link word", 32'(k), {24'h0, rx});
    end
    st_chk(1'b1, 1'b0, 1'b1);
    for (k = 1; k <= 3; k++) begin
      apb(1'b0, `SSF_OFS_DATA, 32'h0);
      chk("enh rx data", 32'(k * 17), rd);
    end
    st_chk(1'b1, 1'b0, 1'b0);
    tally_and_finish();
  end
endmodule // ssf_top_tb
`default_nettype wire
